// ### spci_pkg.sv
// Constants for the serial port control, error and interrupt block
//
// Overview of operation
// - Select handling disabled: slave selected unless phase zero, no role fault detected.
// - Select handling disabled: select pin released as a general purpose line.
// - Byte completing while previous byte unread raises the overrun flag.
// - On overrun the new byte is dropped; the unread byte stays.
// - Three interrupt sources: transfer done, role fault, transmit empty.
// - Transfer done set per byte; interrupts only with tx-empty enable clear.
// - Transmit empty set while buffer free; interrupts only with enable set.
// - Role fault set when master sees select low or slave sees select rise.
// - Control bit 6 enables; clearing it resets internal state.
// - Control bit 5 disables select use; slave ignores it when phase zero.
// - Select use disabled means no role fault interrupt request.
// - Control bit 4 chooses role: zero slave, one master.
// - Control bit 3 sets the serial clock idle level.
// - Control bit 2 chooses the sampling edge.
// - Rate bits 7,1,0 pick divide 4 to 128; 000 and 111 invalid.
// - Control register resets to 0x14.
// - Role fault interrupt only with its enable set.
// - Master role fault clears enable and master bits.
// - Transfer done clears on status read then data access.
// - Overrun and role fault clear on status read.
package spci_pkg;
  localparam logic [7:0] SPCI_CTRL_ADDR   = 8'hD4;
  localparam logic [7:0] SPCI_STAT_ADDR   = 8'hD5;
  localparam logic [7:0] SPCI_DATA_ADDR   = 8'hC5;
  localparam logic [7:0] SPCI_CTRL_RESET  = 8'h14;
  localparam logic [7:0] SPCI_STAT_RESET  = 8'h08;
  localparam int         SPCI_RATE_HI_BIT = 7;
  localparam int         SPCI_EN_BIT      = 6;
  localparam int         SPCI_SELECT_PIN_DISABLE_BIT   = 5;
  localparam int         SPCI_MASTER_ROLE_BIT    = 4;
  localparam int         SPCI_IDLE_BIT    = 3;
  localparam int         SPCI_EDGE_BIT    = 2;
  localparam int         SPCI_RATE_MID_BIT = 1;
  localparam int         SPCI_RATE_LO_BIT = 0;
  localparam int         SPCI_DONE_BIT    = 7;
  localparam int         SPCI_OVR_BIT     = 5;
  localparam int         SPCI_FAULT_BIT   = 4;
  localparam int         SPCI_TXE_BIT     = 3;
  localparam int         SPCI_LSB_BIT     = 2;
  localparam int         SPCI_TXEIE_BIT   = 1;
  localparam int         SPCI_FAULTIE_BIT = 0;
  localparam int         SPCI_BITS        = 8;
  localparam logic [3:0] SPCI_BITCNT_RESET = 4'h0;
  localparam logic [6:0] SPCI_DIV_RESET   = 7'h00;
  typedef enum logic [1:0] {SPCI_IDLE, SPCI_LOAD, SPCI_SHIFT, SPCI_DONE}
    spci_state_t;
endpackage

// ### spci_core.sv
// Serial port control, error detection and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module spci_core (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  output logic            irq_out,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe_n_out,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe_n_out,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe_n_out,
  input  wire logic       ss_n_in,
  output logic            ss_pin_gpio_out
);
  // Two-flop synchronisers for pins
  logic [3:0] sync1_reg, sync2_reg, sync3_reg;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
      sync3_reg <= 4'hF;
    end else begin
      sync1_reg <= {ss_n_in, sck_in, mosi_in, miso_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end
  logic ss_s, sck_s, sck_d, mosi_s, miso_s;
  assign ss_s   = sync2_reg[3];
  assign sck_s  = sync2_reg[2];
  assign sck_d  = sync3_reg[2];
  assign mosi_s = sync2_reg[1];
  assign miso_s = sync2_reg[0];

  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] stat_reg, stat_next;
  logic [7:0] rx_reg, rx_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] bit_reg, bit_next;
  logic [6:0] div_reg, div_next;
  logic       sck_reg, sck_next;
  logic       txf_reg, txf_next;
  logic       stat_rd_reg, stat_rd_next;
  logic       ss_d_reg;
  logic [7:0] rdata_reg, rdata_next;
  spci_pkg::spci_state_t state_reg, state_next;

  logic en, master_role, select_pin_disable, clock_idle_level, clock_sample_edge, lsbf;
  assign en    = ctrl_reg[spci_pkg::SPCI_EN_BIT];
  assign master_role  = ctrl_reg[spci_pkg::SPCI_MASTER_ROLE_BIT];
  assign select_pin_disable = ctrl_reg[spci_pkg::SPCI_SELECT_PIN_DISABLE_BIT];
  assign clock_idle_level  = ctrl_reg[spci_pkg::SPCI_IDLE_BIT];
  assign clock_sample_edge  = ctrl_reg[spci_pkg::SPCI_EDGE_BIT];
  assign lsbf  = stat_reg[spci_pkg::SPCI_LSB_BIT];

  // Select usage; slave with phase zero needs the pin for framing
  logic ss_used, selected;
  assign ss_used  = !select_pin_disable || (!master_role && !clock_sample_edge);
  assign selected = ss_used ? !ss_s : 1'b1;

  // Half-period less one, in system clocks, from rate code
  logic [2:0] rate;
  logic [6:0] half;
  logic       rate_ok;
  assign rate = {ctrl_reg[spci_pkg::SPCI_RATE_HI_BIT],
                 ctrl_reg[spci_pkg::SPCI_RATE_MID_BIT],
                 ctrl_reg[spci_pkg::SPCI_RATE_LO_BIT]};
  always_comb begin
    rate_ok = 1'b1;
    case (rate)
      3'h1:    half = 7'h01;
      3'h2:    half = 7'h03;
      3'h3:    half = 7'h07;
      3'h4:    half = 7'h0F;
      3'h5:    half = 7'h1F;
      3'h6:    half = 7'h3F;
      default: begin
        half    = 7'h00;
        rate_ok = 1'b0;
      end
    endcase
  end

  logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
  assign wr_ctrl = wr_in && (addr_in == spci_pkg::SPCI_CTRL_ADDR);
  assign wr_stat = wr_in && (addr_in == spci_pkg::SPCI_STAT_ADDR);
  assign wr_data = wr_in && (addr_in == spci_pkg::SPCI_DATA_ADDR);
  assign rd_stat = rd_in && (addr_in == spci_pkg::SPCI_STAT_ADDR);
  assign rd_data = rd_in && (addr_in == spci_pkg::SPCI_DATA_ADDR);

  // Edge events: master from divider, slave from synchronised clock
  logic m_tick, s_lead, s_trail, lead, trail;
  assign m_tick  = (div_reg == half) && (state_reg == spci_pkg::SPCI_SHIFT);
  assign s_lead  = (sck_s != sck_d) && (sck_s != clock_idle_level);
  assign s_trail = (sck_s != sck_d) && (sck_s == clock_idle_level);
  assign lead    = master_role ? (m_tick && (sck_reg == clock_idle_level)) : (s_lead && selected);
  assign trail   = master_role ? (m_tick && (sck_reg != clock_idle_level)) : (s_trail && selected);
  logic smp, shf;
  assign smp = clock_sample_edge ? trail : lead;
  assign shf = clock_sample_edge ? lead : trail;

  logic fault_now, byte_end;
  always_comb begin
    ctrl_next    = ctrl_reg;
    stat_next    = stat_reg;
    rx_next      = rx_reg;
    tx_next      = tx_reg;
    sh_next      = sh_reg;
    bit_next     = bit_reg;
    div_next     = div_reg;
    sck_next     = sck_reg;
    txf_next     = txf_reg;
    state_next   = state_reg;
    stat_rd_next = stat_rd_reg;
    rdata_next   = 8'h00;
    byte_end     = 1'b0;
    // Master sees select low, or slave sees select rise, in any state while enabled
    fault_now = en && ss_used && !select_pin_disable &&
                (master_role ? !ss_s : (ss_s && !ss_d_reg));
    if (rd_stat) rdata_next = stat_reg & 8'hBF;
    if (rd_data) rdata_next = rx_reg;
    if (rd_in && addr_in == spci_pkg::SPCI_CTRL_ADDR) rdata_next = ctrl_reg;
    if (wr_ctrl) ctrl_next = wdata_in;
    if (wr_stat) begin
      stat_next[spci_pkg::SPCI_LSB_BIT]     = wdata_in[spci_pkg::SPCI_LSB_BIT];
      stat_next[spci_pkg::SPCI_TXEIE_BIT]   = wdata_in[spci_pkg::SPCI_TXEIE_BIT];
      stat_next[spci_pkg::SPCI_FAULTIE_BIT] =
        wdata_in[spci_pkg::SPCI_FAULTIE_BIT];
    end
    if (wr_data) begin
      tx_next  = wdata_in;
      txf_next = 1'b1;
    end
    // Status read arms the done clear, then data access completes it
    if (rd_stat) begin
      stat_next[spci_pkg::SPCI_OVR_BIT]   = 1'b0;
      stat_next[spci_pkg::SPCI_FAULT_BIT] = 1'b0;
      stat_rd_next = 1'b1;
    end
    if ((rd_data || wr_data) && stat_rd_reg) begin
      stat_next[spci_pkg::SPCI_DONE_BIT] = 1'b0;
      stat_rd_next = 1'b0;
    end
    if (!en) begin
      // Disabled port holds the engine in reset
      state_next = spci_pkg::SPCI_IDLE;
      bit_next   = spci_pkg::SPCI_BITCNT_RESET;
      div_next   = spci_pkg::SPCI_DIV_RESET;
      sck_next   = clock_idle_level;
    end else begin
      case (state_reg)
        spci_pkg::SPCI_IDLE: begin
          sck_next = master_role ? clock_idle_level : sck_reg;
          bit_next = spci_pkg::SPCI_BITCNT_RESET;
          if (txf_reg || wr_data || (!master_role && selected)) begin
            state_next = spci_pkg::SPCI_LOAD;
          end
        end
        spci_pkg::SPCI_LOAD: begin
          if (txf_reg) sh_next = tx_reg;
          txf_next   = wr_data;
          div_next   = spci_pkg::SPCI_DIV_RESET;
          state_next = (master_role && !rate_ok) ? spci_pkg::SPCI_IDLE
                                          : spci_pkg::SPCI_SHIFT;
        end
        spci_pkg::SPCI_SHIFT: begin
          div_next = m_tick ? spci_pkg::SPCI_DIV_RESET
                            : div_reg + 7'h01;
          if (master_role && m_tick) sck_next = !sck_reg;
          if (smp) begin
            if (lsbf) sh_next = {(master_role ? miso_s : mosi_s), sh_reg[7:1]};
            else      sh_next = {sh_reg[6:0], (master_role ? miso_s : mosi_s)};
            bit_next = bit_reg + 4'h1;
          end
          // Trailing edge on or after the eighth sample ends the byte
          if (trail && bit_next == 4'(spci_pkg::SPCI_BITS)) begin
            state_next = spci_pkg::SPCI_DONE;
          end
          if (!master_role && !selected) state_next = spci_pkg::SPCI_IDLE;
        end
        spci_pkg::SPCI_DONE: begin
          byte_end   = 1'b1;
          state_next = spci_pkg::SPCI_IDLE;
          if (stat_reg[spci_pkg::SPCI_DONE_BIT]) begin
            stat_next[spci_pkg::SPCI_OVR_BIT] = 1'b1;
          end else begin
            rx_next = sh_reg;
          end
          stat_next[spci_pkg::SPCI_DONE_BIT] = 1'b1;
        end
        default: state_next = spci_pkg::SPCI_IDLE;
      endcase
    end
    if (fault_now) begin
      stat_next[spci_pkg::SPCI_FAULT_BIT] = 1'b1;
      state_next = spci_pkg::SPCI_IDLE;
      if (master_role) begin
        ctrl_next[spci_pkg::SPCI_EN_BIT]   = 1'b0;
        ctrl_next[spci_pkg::SPCI_MASTER_ROLE_BIT] = 1'b0;
      end
    end
    stat_next[spci_pkg::SPCI_TXE_BIT] = !txf_next;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_reg    <= spci_pkg::SPCI_CTRL_RESET;
      stat_reg    <= spci_pkg::SPCI_STAT_RESET;
      rx_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      sh_reg      <= 8'h00;
      bit_reg     <= spci_pkg::SPCI_BITCNT_RESET;
      div_reg     <= spci_pkg::SPCI_DIV_RESET;
      sck_reg     <= 1'b0;
      txf_reg     <= 1'b0;
      stat_rd_reg <= 1'b0;
      ss_d_reg    <= 1'b1;
      rdata_reg   <= 8'h00;
      state_reg   <= spci_pkg::SPCI_IDLE;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      rx_reg      <= rx_next;
      tx_reg      <= tx_next;
      sh_reg      <= sh_next;
      bit_reg     <= bit_next;
      div_reg     <= div_next;
      sck_reg     <= sck_next;
      txf_reg     <= txf_next;
      stat_rd_reg <= stat_rd_next;
      ss_d_reg    <= ss_s;
      rdata_reg   <= rdata_next;
      state_reg   <= state_next;
    end
  end

  // Gated interrupt sources
  logic irq_done, irq_txe, irq_fault;
  assign irq_done  = stat_reg[spci_pkg::SPCI_DONE_BIT] &&
                     !stat_reg[spci_pkg::SPCI_TXEIE_BIT];
  assign irq_txe   = stat_reg[spci_pkg::SPCI_TXE_BIT] &&
                     stat_reg[spci_pkg::SPCI_TXEIE_BIT];
  assign irq_fault = stat_reg[spci_pkg::SPCI_FAULT_BIT] &&
                     stat_reg[spci_pkg::SPCI_FAULTIE_BIT] && !select_pin_disable;
  assign irq_out   = irq_done || irq_txe || irq_fault;

  assign rdata_out       = rdata_reg;
  assign sck_out         = sck_reg;
  assign sck_oe_n_out    = !(en && master_role);
  assign mosi_out        = lsbf ? sh_reg[0] : sh_reg[7];
  assign mosi_oe_n_out   = !(en && master_role);
  assign miso_out        = lsbf ? sh_reg[0] : sh_reg[7];
  assign miso_oe_n_out   = !(en && !master_role && selected);
  assign ss_pin_gpio_out = select_pin_disable;
  logic unused_shf;
  assign unused_shf = shf;
endmodule
`default_nettype wire

// ### spci_core_assertions.sv
// Port-level assertions for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module spci_core_assertions (
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_out,
  input wire logic       sck_oe_n_out,
  input wire logic       ss_pin_gpio_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_stat;
    rd_in && addr_in == spci_pkg::SPCI_STAT_ADDR;
  endsequence
  sequence s_ctrl;
    wr_in && addr_in == spci_pkg::SPCI_CTRL_ADDR;
  endsequence
  // Irq taken in the read cycle, so it matches the flags read back
  chk_txe_irq: assert property (
    s_stat ##1 (rdata_out[3] && rdata_out[1]) |-> $past(irq_out))
    else $error("irq low with tx empty enabled");
  chk_done_irq: assert property (
    s_stat ##1 (rdata_out[7] && !rdata_out[1]) |-> $past(irq_out))
    else $error("irq low with transfer done");
  chk_fault_irq: assert property (
    s_stat ##1 (rdata_out[4] && rdata_out[0]) |-> $past(irq_out))
    else $error("irq low with role fault enabled");
  chk_irq_gated: assert property (
    s_stat ##1 !(rdata_out[7] && !rdata_out[1] ||
      rdata_out[3] && rdata_out[1] || rdata_out[4] && rdata_out[0])
    |-> !$past(irq_out))
    else $error("irq high with no enabled source");
  chk_unmapped_zero: assert property (
    rd_in && addr_in != spci_pkg::SPCI_CTRL_ADDR &&
    addr_in != spci_pkg::SPCI_STAT_ADDR &&
    addr_in != spci_pkg::SPCI_DATA_ADDR |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  chk_gpio_release: assert property (
    s_ctrl ##0 wdata_in[2] |=> ss_pin_gpio_out == $past(wdata_in[5]))
    else $error("select pin release wrong");
  chk_role_pins: assert property (
    s_ctrl ##0 (wdata_in[6] && wdata_in[5])
    |=> sck_oe_n_out == !$past(wdata_in[4]))
    else $error("clock pin drive does not follow role");
  // Port off, so no hardware event can alter the value
  chk_ctrl_echo: assert property (
    s_ctrl ##0 !wdata_in[6] ##2 (rd_in &&
    addr_in == spci_pkg::SPCI_CTRL_ADDR) |=> rdata_out == $past(wdata_in, 3))
    else $error("control readback differs");
endmodule
bind spci_core spci_core_assertions chk_u (.clk_sys_in, .rst_n_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .irq_out,
  .sck_oe_n_out, .ss_pin_gpio_out);
`default_nettype wire

// ### spci_peer.sv
// External master model on the far side of the serial link
`timescale 1ns/10ps
`default_nettype none
module spci_peer (
  output logic sck_out,
  output logic mosi_out,
  output logic ss_n_out
);
  initial begin
    sck_out = 1'b0;
    mosi_out = 1'b0;
    ss_n_out = 1'b1;
  end
  task automatic select(input logic lvl);
    #80 ss_n_out = lvl;
  endtask
  // Clock low at rest, moves only during send, whatever the select level; data set on leading edge
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #40 sck_out = 1'b1;
      mosi_out = b[i];
      #40 sck_out = 1'b0;
    end
    #40 mosi_out = ~b[0];
  endtask
endmodule
`default_nettype wire

// ### spci_core_tb.sv
// Self-checking bench for the serial port control block
`timescale 1ns/10ps
`default_nettype none
module spci_core_tb;
  logic clk_sys, rst_n, wr, rd, irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n;
  logic miso_o, miso_oe_n, gpio, p_sck, p_mosi, p_ss_n, miso_last;
  logic [7:0] addr, wdata, rdata, v, d;
  int n_errors, checked, cyc, seed, n;
  // Undriven miso shows the inverse of its last value, not a guess
  wire logic sck_w = sck_oe_n ? p_sck : sck_o;
  wire logic mosi_w = mosi_oe_n ? p_mosi : mosi_o;
  wire logic miso_w = miso_oe_n ? ~miso_last : miso_o;
  spci_core dut_u (.clk_sys_in(clk_sys), .rst_n_in(rst_n), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .irq_out(irq), .sck_in(sck_w), .sck_out(sck_o), .sck_oe_n_out(sck_oe_n),
    .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe_n_out(mosi_oe_n),
    .miso_in(miso_w), .miso_out(miso_o), .miso_oe_n_out(miso_oe_n),
    .ss_n_in(p_ss_n), .ss_pin_gpio_out(gpio));
  spci_peer peer_u (.sck_out(p_sck), .mosi_out(p_mosi), .ss_n_out(p_ss_n));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (!miso_oe_n) miso_last <= miso_o;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One idle cycle after each access keeps strobes single-driven
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] x);
    addr <= a;
    wdata <= x;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    seed = 32'h46CB7EB5;
    clk_sys = 1'b0;
    rst_n = 1'b0;
    {addr, wdata, wr, rd, miso_last} = '0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    bus(0, spci_pkg::SPCI_CTRL_ADDR, 8'h00);
    chk(v, 8'h14);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v, 8'h08);
    bus(0, 8'h00, 8'h00);
    chk(v, 8'h00);
    repeat (4) begin
      d = 8'($random(seed)) & 8'hBF;
      bus(1, spci_pkg::SPCI_CTRL_ADDR, d);
      bus(0, spci_pkg::SPCI_CTRL_ADDR, 8'h00);
      chk(v, d);
    end
    for (int c = 1; c < 7; c++) begin
      d = {c[2], 3'b111, c[0], 1'b1, c[1:0]};
      bus(1, spci_pkg::SPCI_CTRL_ADDR, d);
      @(negedge clk_sys);
      chk({7'h00, sck_o}, {7'h00, c[0]});
      bus(1, spci_pkg::SPCI_DATA_ADDR, 8'($random(seed)));
      n = 0;
      while (sck_o === c[0] && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
      n = 0;
      while (sck_o !== c[0] && n < 400) begin
        @(negedge clk_sys);
        n++;
      end
      chk(8'(n), 8'(1 << c));
      repeat (16 << c) @(posedge clk_sys);
      bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
      chk(v & 8'h80, 8'h80);
      bus(1, spci_pkg::SPCI_CTRL_ADDR, 8'h14);
    end
    bus(0, spci_pkg::SPCI_DATA_ADDR, 8'h00);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'hB0, 8'h00);
    bus(1, spci_pkg::SPCI_STAT_ADDR, 8'h02);
    chk({7'h00, irq}, 8'h01);
    bus(1, spci_pkg::SPCI_STAT_ADDR, 8'h01);
    chk({7'h00, irq}, 8'h00);
    bus(1, spci_pkg::SPCI_CTRL_ADDR, 8'h44);
    peer_u.select(1'b0);
    d = 8'($random(seed));
    peer_u.send(d);
    peer_u.send(~d);
    repeat (8) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h01);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'hB0, 8'hA0);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'h30, 8'h00);
    bus(0, spci_pkg::SPCI_DATA_ADDR, 8'h00);
    chk(v, d);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'h80, 8'h00);
    peer_u.select(1'b1);
    repeat (8) @(posedge clk_sys);
    chk({7'h00, irq}, 8'h01);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'h10, 8'h10);
    bus(1, spci_pkg::SPCI_CTRL_ADDR, 8'h64);
    chk({7'h00, gpio}, 8'h01);
    peer_u.select(1'b0);
    peer_u.select(1'b1);
    peer_u.send(d);
    repeat (8) @(posedge clk_sys);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'h90, 8'h80);
    bus(0, spci_pkg::SPCI_DATA_ADDR, 8'h00);
    chk(v, d);
    bus(1, spci_pkg::SPCI_CTRL_ADDR, 8'h51);
    peer_u.select(1'b0);
    repeat (8) @(posedge clk_sys);
    bus(0, spci_pkg::SPCI_CTRL_ADDR, 8'h00);
    chk(v & 8'h50, 8'h00);
    bus(0, spci_pkg::SPCI_STAT_ADDR, 8'h00);
    chk(v & 8'h10, 8'h10);
    wrap_up();
  end
endmodule
`default_nettype wire
